//--- tsc_defines.svh
// offsets, field positions, reset values and counts of the sideband control
// Overview of operation
// - default polarity: low hot-plug is released, high is sink present
// - low polarity option: low hot-plug is present, high is released
// - stream configuration outputs lock flag, 1 locked, 0 not locked
// - one active-high interrupt request output toward the processor
// - status word is taken only while its valid strobe is high
// - field parity is sampled in the start-of-frame cycle
// - stream is bridged to native timing, clocked on pixel clock
// - native configuration outputs active-high pixel-synchronous reset
// - processor-bus reset returns the whole block and its registers to their reset values
// - video stream reset clears only the video stream path
// - audio stream reset clears only the audio stream path
// - lane output data is clocked on the lane clock input
// - native configuration ignores video stream reset input
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_ADDR_W       8
`define TSC_DATA_W       32
`define TSC_REG_STATUS   8'h00
`define TSC_REG_CTRL     8'h04
`define TSC_REG_EVENT    8'h08
`define TSC_REG_FRAMES   8'h0c
`define TSC_CTRL_RESET   3'h1
`define TSC_CTRL_IRQ_EN  0
`define TSC_CTRL_VRST    1
`define TSC_CTRL_ARST    2
`define TSC_ST_HPD       0
`define TSC_ST_LINK      1
`define TSC_ST_VID       2
`define TSC_ST_LOCK      3
`define TSC_ST_FIELD     4
`define TSC_EV_HPD       0
`define TSC_EV_LOCK      1
`define TSC_EV_SB        2
`define TSC_SY_HPD       0
`define TSC_SY_SBW0      1
`define TSC_SY_SBW1      2
`define TSC_SY_SBV       3
`define TSC_SY_FID       4
`define TSC_SY_SOF       5
`define TSC_SY_SVAL      6
`define TSC_SY_PIX       7
`define TSC_SY_LANE      8
`define TSC_SY_VRN       9
`define TSC_SY_ARN       10
`define TSC_SYNC_W       11
`define TSC_RST_HOLD     8'h10
`define TSC_LOCK_FRAMES  2'h3
`define TSC_LOCK_TIMEOUT 24'h07a120
`endif

//--- tsc_pkg.sv
// types shared by the sideband control modules
`include "tsc_defines.svh"
package tsc_pkg;
  typedef enum logic [1:0] {
    tsc_lk_idle   = 2'b00,
    tsc_lk_acq    = 2'b01,
    tsc_lk_locked = 2'b10
  } tsc_lock_t;
  typedef logic [`TSC_SYNC_W-1:0] tsc_sync_t;
  typedef struct packed {
    logic video_rdy;
    logic link_rdy;
  } tsc_sb_t;
endpackage

//--- tsc_sync_if.sv
// raw pin levels in, synchronised levels out
interface tsc_sync_if;
  tsc_pkg::tsc_sync_t raw;
  tsc_pkg::tsc_sync_t sync;
  modport ctl
  (
    output raw,
    input  sync
  );
  modport stage
  (
    input  raw,
    output sync
  );
endinterface

//--- tsc_sync.sv
// two-flop synchroniser bank for every foreign input
module tsc_sync
(
  input  wire logic   clk,
  input  wire logic   rst,
  tsc_sync_if.stage   sy
);
  tsc_pkg::tsc_sync_t meta;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      meta <= '0;
    else
      meta <= sy.raw;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sy.sync <= '0;
    else
      sy.sync <= meta;
  end
endmodule

//--- tsc_ctrl.sv
// sideband status, hot-plug, lock, reset and lane glue with register port
`include "tsc_defines.svh"
module tsc_ctrl
#(
  parameter bit          HPD_ACTIVE_LOW = 1'b0,
  parameter bit          NATIVE_VIDEO   = 1'b0,
  parameter logic [23:0] LOCK_TIMEOUT   = `TSC_LOCK_TIMEOUT
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`TSC_ADDR_W-1:0] addr,
  input  wire logic [`TSC_DATA_W-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`TSC_DATA_W-1:0] rdata,
  input  wire logic                   hpd_pin,
  input  wire logic [1:0]             sideband_status_word,
  input  wire logic                   sideband_status_valid,
  input  wire logic                   field_id_in,
  input  wire logic                   stream_sof,
  input  wire logic                   stream_valid,
  input  wire logic                   pixel_clk_in,
  input  wire logic                   lane_clk_in,
  input  wire logic                   video_stream_rst_n_in,
  input  wire logic                   audio_stream_rst_n_in,
  output logic                        locked,
  output logic                        irq,
  output logic                        video_path_rst_n,
  output logic                        audio_path_rst_n,
  output logic                        pixel_rst,
  output logic                        native_frame_start,
  output logic                        native_field,
  output logic [1:0]                  lane_data,
  output logic                        lane_valid
);
  tsc_sync_if          sy();
  tsc_pkg::tsc_sync_t  s;
  tsc_pkg::tsc_sync_t  s_d;
  tsc_pkg::tsc_sb_t    sb;
  tsc_pkg::tsc_lock_t  lk;
  tsc_pkg::tsc_lock_t  next_lk;
  logic                hpd_present;
  logic [2:0]          ctrl;
  logic [2:0]          pend;
  logic [2:0]          ev;
  logic [7:0]          vhold;
  logic [7:0]          ahold;
  logic                vreq;
  logic                areq;
  logic                pix_edge;
  logic                lane_edge;
  logic                frame_ev;
  logic                field;
  logic                bridge_pend;
  logic [23:0]         timer;
  logic [1:0]          frames;
  logic [15:0]         frame_cnt;
  logic                lock_now;
  logic                hpd_now;
  logic                sb_take;

  function automatic logic rise
  (
    input logic cur,
    input logic prev
  );
    rise = cur & ~prev;
  endfunction

  function automatic logic [7:0] hold_next
  (
    input logic       req,
    input logic [7:0] cnt
  );
    if (req)
      hold_next = `TSC_RST_HOLD;
    else if (cnt != 8'h00)
      hold_next = cnt - 8'h01;
    else
      hold_next = 8'h00;
  endfunction

  tsc_sync u_sync
  (
    .clk (clk),
    .rst (rst),
    .sy  (sy.stage)
  );

  always_comb
  begin
    sy.raw = '0;
    sy.raw[`TSC_SY_HPD]  = hpd_pin;
    sy.raw[`TSC_SY_SBW0] = sideband_status_word[0];
    sy.raw[`TSC_SY_SBW1] = sideband_status_word[1];
    sy.raw[`TSC_SY_SBV]  = sideband_status_valid;
    sy.raw[`TSC_SY_FID]  = field_id_in;
    sy.raw[`TSC_SY_SOF]  = stream_sof;
    sy.raw[`TSC_SY_SVAL] = stream_valid;
    sy.raw[`TSC_SY_PIX]  = pixel_clk_in;
    sy.raw[`TSC_SY_LANE] = lane_clk_in;
    sy.raw[`TSC_SY_VRN]  = video_stream_rst_n_in;
    sy.raw[`TSC_SY_ARN]  = audio_stream_rst_n_in;
  end

  assign s = sy.sync;

  // delayed copy of the second stage for edge finding
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_d <= '0;
    else
      s_d <= s;
  end

  assign pix_edge  = rise(s[`TSC_SY_PIX], s_d[`TSC_SY_PIX]);
  assign lane_edge = rise(s[`TSC_SY_LANE], s_d[`TSC_SY_LANE]);

  assign hpd_now = HPD_ACTIVE_LOW ? ~s[`TSC_SY_HPD] : s[`TSC_SY_HPD];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hpd_present <= 1'b0;
    else
      hpd_present <= hpd_now;
  end

  assign sb_take = s[`TSC_SY_SBV];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sb <= '0;
    else if (sb_take)
    begin
      sb.link_rdy  <= s[`TSC_SY_SBW0];
      sb.video_rdy <= s[`TSC_SY_SBW1];
    end
  end

  assign vreq = ctrl[`TSC_CTRL_VRST]
              | (~NATIVE_VIDEO & ~s[`TSC_SY_VRN]);
  assign areq = ctrl[`TSC_CTRL_ARST] | ~s[`TSC_SY_ARN];

  // stretch keeps the path quiet while its clock settles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      vhold <= `TSC_RST_HOLD;
    else
      vhold <= hold_next(vreq, vhold);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ahold <= `TSC_RST_HOLD;
    else
      ahold <= hold_next(areq, ahold);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      video_path_rst_n <= 1'b0;
    else
      video_path_rst_n <= ~(vreq | (vhold != 8'h00));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      audio_path_rst_n <= 1'b0;
    else
      audio_path_rst_n <= ~(areq | (ahold != 8'h00));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pixel_rst <= 1'b1;
    else if (pix_edge)
      pixel_rst <= vreq | (vhold != 8'h00);
  end

  // sof shorter than one clock may be missed by the sync
  assign frame_ev = ~NATIVE_VIDEO & video_path_rst_n
                  & rise(s[`TSC_SY_SOF], s_d[`TSC_SY_SOF])
                  & s[`TSC_SY_SVAL];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      field <= 1'b0;
    else if (frame_ev)
      field <= s[`TSC_SY_FID];
  end

  // bridge frame start to pixel edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bridge_pend <= 1'b0;
    else if (frame_ev)
      bridge_pend <= 1'b1;
    else if (pix_edge)
      bridge_pend <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      native_frame_start <= 1'b0;
    else
      native_frame_start <= pix_edge & bridge_pend & ~pixel_rst;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      native_field <= 1'b0;
    else if (pix_edge & bridge_pend)
      native_field <= field;
  end

  // time since the last frame start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer <= 24'h000000;
    else if (frame_ev | ~video_path_rst_n)
      timer <= 24'h000000;
    else if (timer != LOCK_TIMEOUT)
      timer <= timer + 24'h000001;
  end

  always_comb
  begin
    next_lk = lk;
    case (lk)
      tsc_pkg::tsc_lk_idle:
        if (frame_ev)
          next_lk = tsc_pkg::tsc_lk_acq;
      tsc_pkg::tsc_lk_acq:
        if (timer == LOCK_TIMEOUT)
          next_lk = tsc_pkg::tsc_lk_idle;
        else if (frame_ev && frames == `TSC_LOCK_FRAMES)
          next_lk = tsc_pkg::tsc_lk_locked;
      tsc_pkg::tsc_lk_locked:
        if (timer == LOCK_TIMEOUT)
          next_lk = tsc_pkg::tsc_lk_idle;
      default:
        next_lk = tsc_pkg::tsc_lk_idle;
    endcase
    if (!video_path_rst_n || NATIVE_VIDEO)
      next_lk = tsc_pkg::tsc_lk_idle;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lk <= tsc_pkg::tsc_lk_idle;
    else
      lk <= next_lk;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frames <= 2'h0;
    else if (next_lk == tsc_pkg::tsc_lk_idle)
      frames <= 2'h0;
    else if (frame_ev && frames != `TSC_LOCK_FRAMES)
      frames <= frames + 2'h1;
  end

  assign lock_now = (next_lk == tsc_pkg::tsc_lk_locked);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      locked <= 1'b0;
    else
      locked <= lock_now;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frame_cnt <= 16'h0000;
    else if (frame_ev)
      frame_cnt <= frame_cnt + 16'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lane_data <= 2'h0;
    else if (lane_edge)
      lane_data <= {sb.video_rdy, sb.link_rdy};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lane_valid <= 1'b0;
    else if (lane_edge)
      lane_valid <= sb.link_rdy & hpd_present;
  end

  // events worth telling the processor about
  always_comb
  begin
    ev = 3'h0;
    ev[`TSC_EV_HPD]  = hpd_now ^ hpd_present;
    ev[`TSC_EV_LOCK] = lock_now ^ locked;
    ev[`TSC_EV_SB]   = sb_take
                     & ({s[`TSC_SY_SBW1], s[`TSC_SY_SBW0]} != sb);
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend <= 3'h0;
    else if (wr && addr == `TSC_REG_EVENT)
      pend <= (pend & ~wdata[2:0]) | ev;
    else
      pend <= pend | ev;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= ctrl[`TSC_CTRL_IRQ_EN] & (|pend);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl <= `TSC_CTRL_RESET;
    else if (wr && addr == `TSC_REG_CTRL)
      ctrl <= wdata[2:0];
  end

  // unmapped addresses read zero, writes to them are dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= '0;
    else if (rd)
    begin
      rdata <= '0;
      case (addr)
        `TSC_REG_STATUS:
        begin
          rdata[`TSC_ST_HPD]   <= hpd_present;
          rdata[`TSC_ST_LINK]  <= sb.link_rdy;
          rdata[`TSC_ST_VID]   <= sb.video_rdy;
          rdata[`TSC_ST_LOCK]  <= locked;
          rdata[`TSC_ST_FIELD] <= field;
        end
        `TSC_REG_CTRL:
          rdata[2:0] <= ctrl;
        `TSC_REG_EVENT:
          rdata[2:0] <= pend;
        `TSC_REG_FRAMES:
          rdata[15:0] <= frame_cnt;
        default:
          rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end
endmodule

//--- tsc_ctrl_chk.sv
// port-level assertions for the sideband control block
module tsc_ctrl_chk
#(
  parameter bit          NATIVE_VIDEO = 1'b0,
  parameter logic [23:0] LOCK_TIMEOUT = 24'h0000c8
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        locked,
  input wire logic        video_path_rst_n,
  input wire logic        audio_path_rst_n,
  input wire logic        pixel_rst,
  input wire logic        native_frame_start,
  input wire logic [1:0]  lane_data,
  input wire logic        lane_clk_in,
  input wire logic        sideband_status_valid,
  input wire logic        video_stream_rst_n_in,
  input wire logic        audio_stream_rst_n_in
);
  logic [4:0] quiet;
  // cycles since the last status strobe, saturating
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      quiet <= 5'h00;
    else if (sideband_status_valid)
      quiet <= 5'h00;
    else if (quiet != 5'h14)
      quiet <= quiet + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  AST_RST_VALUES: assert property (disable iff (1'b0)
    rst |-> !irq && !locked && !video_path_rst_n && !audio_path_rst_n)
    else $error("outputs not cleared in reset");
  AST_PATH_HOLD: assert property ($fell(rst) |->
    (!video_path_rst_n && !audio_path_rst_n)[*8])
    else $error("path reset released too early");
  AST_VIDEO_RST: assert property (
    (!NATIVE_VIDEO && !video_stream_rst_n_in)[*5] |-> !video_path_rst_n)
    else $error("video path not reset");
  AST_AUDIO_RST: assert property (
    (!audio_stream_rst_n_in)[*5] |-> !audio_path_rst_n)
    else $error("audio path not reset");
  AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("interrupt dropped without a write");
  AST_SB_QUIET: assert property (quiet == 5'h14 |-> $stable(lane_data))
    else $error("lane data moved without a strobe");
  AST_LANE_EDGE: assert property ($changed(lane_data) |->
    $past(lane_clk_in, 2) || $past(lane_clk_in, 3))
    else $error("lane data moved off a lane edge");
  AST_FRAME_PULSE: assert property (
    native_frame_start |=> !native_frame_start)
    else $error("frame start longer than one cycle");
  AST_PIX_RST: assert property ((!video_path_rst_n)[*8] |-> pixel_rst)
    else $error("pixel reset not following path reset");
  cover property ($rose(irq));
  cover property ($rose(locked));
  cover property (native_frame_start);
endmodule

bind tsc_ctrl tsc_ctrl_chk #(.NATIVE_VIDEO(NATIVE_VIDEO),
  .LOCK_TIMEOUT(LOCK_TIMEOUT)) u_chk (.clk, .rst, .wr, .rd, .rdata, .irq,
  .locked, .video_path_rst_n, .audio_path_rst_n, .pixel_rst,
  .native_frame_start, .lane_data, .lane_clk_in, .sideband_status_valid,
  .video_stream_rst_n_in, .audio_stream_rst_n_in);

//--- tsc_sink_model.sv
// sink and phy model: hot-plug level, status word, free-running lane clock
module tsc_sink_model
(
  input  wire logic  clk,
  output logic       hpd_pin,
  output logic [1:0] sideband_status_word,
  output logic       sideband_status_valid,
  output logic       lane_clk_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    hpd_pin = 1'b0;
    sideband_status_word = 2'b00;
    sideband_status_valid = 1'b0;
    lane_clk_in = 1'b0;
    forever #400 lane_clk_in = ~lane_clk_in;
  end
  task automatic plug(input logic on);
    @(posedge clk);
    hpd_pin <= on;
  endtask
  task automatic send(input logic [1:0] w, input logic v);
    @(posedge clk);
    sideband_status_word <= w;
    sideband_status_valid <= v;
    repeat (3) @(posedge clk);
    sideband_status_valid <= 1'b0;
    // stale word inverted so it is never mistaken for valid
    sideband_status_word <= ~w;
  endtask
endmodule

//--- tsc_ctrl_test.sv
// self-checking bench for the sideband control block
`include "tsc_defines.svh"
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
  end
module tsc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] LT = 24'h0000c8;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        hpd;
  logic [1:0]  sb_word;
  logic        sb_valid;
  logic        fid;
  logic        sof;
  logic        svalid;
  logic        pix;
  logic        lane;
  logic        vrst_n;
  logic        arst_n;
  logic        locked;
  logic        irq;
  logic        vpr_n;
  logic        apr_n;
  logic        pixel_rst;
  logic        nfs;
  logic        nfield;
  logic [1:0]  lane_data;
  logic        lane_valid;
  logic        locked_alt;
  logic        vpr_alt;
  logic        lane_valid_alt;
  int          mismatches;
  int          n_tests;
  int          n_fs;
  tsc_ctrl #(.LOCK_TIMEOUT(LT)) u_dut
  (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hpd_pin(hpd), .sideband_status_word(sb_word),
    .sideband_status_valid(sb_valid), .field_id_in(fid), .stream_sof(sof),
    .stream_valid(svalid), .pixel_clk_in(pix), .lane_clk_in(lane),
    .video_stream_rst_n_in(vrst_n), .audio_stream_rst_n_in(arst_n),
    .locked(locked), .irq(irq), .video_path_rst_n(vpr_n),
    .audio_path_rst_n(apr_n), .pixel_rst(pixel_rst),
    .native_frame_start(nfs), .native_field(nfield),
    .lane_data(lane_data), .lane_valid(lane_valid)
  );
  // low-polarity hot-plug, native video build on the same stimulus
  tsc_ctrl #(.HPD_ACTIVE_LOW(1'b1), .NATIVE_VIDEO(1'b1), .LOCK_TIMEOUT(LT))
    u_dut_alt
  (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(), .hpd_pin(hpd), .sideband_status_word(sb_word),
    .sideband_status_valid(sb_valid), .field_id_in(fid), .stream_sof(sof),
    .stream_valid(svalid), .pixel_clk_in(pix), .lane_clk_in(lane),
    .video_stream_rst_n_in(vrst_n), .audio_stream_rst_n_in(arst_n),
    .locked(locked_alt), .irq(), .video_path_rst_n(vpr_alt),
    .audio_path_rst_n(), .pixel_rst(), .native_frame_start(),
    .native_field(), .lane_data(), .lane_valid(lane_valid_alt)
  );
  tsc_sink_model u_sink
  (
    .clk(clk), .hpd_pin(hpd), .sideband_status_word(sb_word),
    .sideband_status_valid(sb_valid), .lane_clk_in(lane)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    pix = 1'b0;
    // half period never lands on a rising clock edge
    forever #160 pix = ~pix;
  end
  always @(posedge clk)
    if (nfs === 1'b1)
      n_fs++;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata & m, e);
  endtask
  task automatic frame(input logic f);
    @(posedge clk);
    sof <= 1'b1;
    svalid <= 1'b1;
    fid <= f;
    repeat (3) @(posedge clk);
    sof <= 1'b0;
    svalid <= 1'b0;
    fid <= ~f;
    wait_cyc(20);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    n_fs = 0;
    rst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fid = 1'b0;
    sof = 1'b0;
    svalid = 1'b0;
    vrst_n = 1'b1;
    arst_n = 1'b1; // audio clock rate lies outside this block
    // clean rising edge so every flop sees the asynchronous reset
    #1;
    rst = 1'b1;
    wait_cyc(7);
    `CHK(pixel_rst, 1'b1);
    @(posedge clk) rst <= 1'b0;
    wait_cyc(30);
    `CHK(pixel_rst, 1'b0);
    rd_chk(`TSC_REG_CTRL, 32'hffffffff, 32'h1);
    rd_chk(8'h10, 32'hffffffff, 32'h0);
    rd_chk(`TSC_REG_STATUS, 32'h1f, 32'h0);
    u_sink.plug(1'b1);
    wait_cyc(5);
    rd_chk(`TSC_REG_STATUS, 32'h1, 32'h1);
    rd_chk(`TSC_REG_EVENT, 32'h7, 32'h1);
    `CHK(irq, 1'b1);
    wr_reg(`TSC_REG_EVENT, 32'h7);
    wait_cyc(2);
    `CHK(irq, 1'b0);
    wr_reg(`TSC_REG_CTRL, 32'h0);
    u_sink.plug(1'b0);
    wait_cyc(6);
    `CHK(irq, 1'b0);
    wr_reg(`TSC_REG_CTRL, 32'h1);
    wait_cyc(2);
    `CHK(irq, 1'b1);
    u_sink.plug(1'b1);
    wait_cyc(6);
    wr_reg(`TSC_REG_EVENT, 32'h7);
    u_sink.send(2'b11, 1'b0);
    wait_cyc(4);
    rd_chk(`TSC_REG_STATUS, 32'h6, 32'h0);
    u_sink.send(2'b10, 1'b1);
    wait_cyc(4);
    rd_chk(`TSC_REG_STATUS, 32'h6, 32'h4);
    u_sink.send(2'b01, 1'b1);
    wait_cyc(20);
    rd_chk(`TSC_REG_STATUS, 32'h6, 32'h2);
    `CHK(lane_data, 2'b01);
    `CHK(lane_valid, 1'b1);
    `CHK(lane_valid_alt, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      frame(i[0]);
      rd_chk(`TSC_REG_STATUS, 32'h10, {27'h0, i[0], 4'h0});
    end
    `CHK(locked, 1'b1);
    `CHK(nfield, 1'b1);
    `CHK(n_fs, 4);
    `CHK(locked_alt, 1'b0);
    rd_chk(`TSC_REG_FRAMES, 32'hffff, 32'h4);
    wait_cyc(int'(LT) + 40);
    `CHK(locked, 1'b0);
    @(posedge clk) vrst_n <= 1'b0;
    wait_cyc(6);
    `CHK(vpr_n, 1'b0);
    `CHK(apr_n, 1'b1);
    `CHK(vpr_alt, 1'b1);
    @(posedge clk) vrst_n <= 1'b1;
    wait_cyc(30);
    `CHK(vpr_n, 1'b1);
    @(posedge clk) arst_n <= 1'b0;
    wait_cyc(6);
    `CHK(apr_n, 1'b0);
    `CHK(vpr_n, 1'b1);
    @(posedge clk) arst_n <= 1'b1;
    wait_cyc(30);
    `CHK(apr_n, 1'b1);
    @(posedge clk) rst <= 1'b1;
    wait_cyc(2);
    `CHK(lane_data, 2'b00);
    `CHK(irq, 1'b0);
    @(posedge clk) rst <= 1'b0;
    wait_cyc(30);
    rd_chk(`TSC_REG_CTRL, 32'h7, 32'h1);
    close_out();
  end
endmodule
